// ==== dwsl_pkg.sv ====
// Package: shared constants and types of the dual wiper serial loader
package dwsl_pkg;
  localparam int DWSL_WORD_BITS = 10;
  localparam int DWSL_DATA_BITS = 8;
  localparam int DWSL_CHANNELS = 2;
  localparam int DWSL_ADDR_HI_POS = 9;
  localparam int DWSL_ADDR_LO_POS = 8;
  localparam logic [7:0] DWSL_MIDSCALE = 8'h80;
  localparam logic [1:0] DWSL_ADDR_CH0 = 2'h0;
  localparam logic [1:0] DWSL_ADDR_CH1 = 2'h1;
  localparam int DWSL_SYS_CLK_NS = 8;
  localparam int DWSL_LINK_HALF_NS = 32;
  localparam int DWSL_HALF_CYCLES = DWSL_LINK_HALF_NS / DWSL_SYS_CLK_NS;
  localparam logic [3:0] DWSL_HALF_CNT = 4'(DWSL_HALF_CYCLES - 1);
  localparam logic [4:0] DWSL_BIT_CNT_INIT = 5'h00;
  localparam int DWSL_SYNC_PINS = 4;
  localparam int DWSL_PIN_SCLK = 0;
  localparam int DWSL_PIN_CS_N = 1;
  localparam int DWSL_PIN_SDI = 2;
  localparam int DWSL_PIN_PDN = 3;
  localparam logic [3:0] DWSL_SYNC_IDLE = 4'ha;
  localparam logic [9:0] DWSL_SHIFT_INIT = 10'h000;
  localparam logic DWSL_SDO_INIT = 1'h1;
  localparam logic [7:0] DWSL_CODE_LOW = 8'h00;
  typedef logic [DWSL_DATA_BITS-1:0] dwsl_code_t;
  typedef enum logic [3:0] {
    DWSL_IDLE = 4'h1,
    DWSL_LOW = 4'h2,
    DWSL_HIGH = 4'h4,
    DWSL_DONE = 4'h8
  } dwsl_state_e;
endpackage

// ==== dwsl_link_if.sv ====
// Interface: serial link between host and loader
interface dwsl_link_if;
  logic sclk;
  logic cs_n;
  logic serial_in;
  logic power_down_n;
  logic serial_out_chain_o;
  logic serial_out_chain_oe;
  wire serial_out_chain;
  assign serial_out_chain = serial_out_chain_oe ? serial_out_chain_o : 1'b1;
  modport device (
    input sclk, cs_n, serial_in, power_down_n,
    output serial_out_chain_o, serial_out_chain_oe
  );
  modport host (
    output sclk, cs_n, serial_in, power_down_n,
    input serial_out_chain
  );
endinterface

// ==== dwsl_device.sv ====
// Device end: shift register, address decode, wiper latches
module dwsl_device
  import dwsl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  dwsl_link_if.device link,
  output logic [7:0] wiper_tap0_o,
  output logic [7:0] wiper_tap1_o,
  output logic high_end_open_o,
  output logic [15:0] wiper_code_o
);
  // ==========================================================
  // Pin gathering
  wire [DWSL_SYNC_PINS-1:0] pin_raw;
  wire [DWSL_SYNC_PINS-1:0] pin_sync;

  assign pin_raw[DWSL_PIN_SCLK] = link.sclk;
  assign pin_raw[DWSL_PIN_CS_N] = link.cs_n;
  assign pin_raw[DWSL_PIN_SDI] = link.serial_in;
  assign pin_raw[DWSL_PIN_PDN] = link.power_down_n;

  // ==========================================================
  // Input synchronisers, two stages per pin
  genvar pin;

  generate
    for (pin = 0; pin < DWSL_SYNC_PINS; pin++) begin : g_sync
      logic stage1;
      logic stage2;

      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          stage1 <= DWSL_SYNC_IDLE[pin];
          stage2 <= DWSL_SYNC_IDLE[pin];
        end else begin
          stage1 <= pin_raw[pin];
          stage2 <= stage1;
        end
      end

      assign pin_sync[pin] = stage2;
    end
  endgenerate

  // ==========================================================
  // Synchronised pin levels
  wire sclk_s;
  wire cs_n_s;
  wire sdi_s;
  wire pdn_s;

  assign sclk_s = pin_sync[DWSL_PIN_SCLK];
  assign cs_n_s = pin_sync[DWSL_PIN_CS_N];
  assign sdi_s = pin_sync[DWSL_PIN_SDI];
  assign pdn_s = pin_sync[DWSL_PIN_PDN];

  // ==========================================================
  // Edge detection
  logic sclk_prev;
  logic cs_n_prev;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_prev <= DWSL_SYNC_IDLE[DWSL_PIN_SCLK];
      cs_n_prev <= DWSL_SYNC_IDLE[DWSL_PIN_CS_N];
    end else begin
      sclk_prev <= sclk_s;
      cs_n_prev <= cs_n_s;
    end
  end

  // ==========================================================
  // Strobes
  wire sclk_rise;
  wire cs_rise;
  wire shift_en;

  assign sclk_rise = sclk_s & ~sclk_prev;
  assign cs_rise = cs_n_s & ~cs_n_prev;
  assign shift_en = sclk_rise & ~cs_n_s;

  // ==========================================================
  // Shift register, one stage per bit
  wire [DWSL_WORD_BITS-1:0] shift_reg;

  genvar stage;

  generate
    for (stage = 0; stage < DWSL_WORD_BITS; stage++) begin : g_shift
      wire stage_in;
      logic stage_q;

      if (stage == 0) begin : g_head
        assign stage_in = sdi_s;
      end else begin : g_body
        assign stage_in = shift_reg[stage-1];
      end

      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          stage_q <= DWSL_SHIFT_INIT[stage];
        end else if (shift_en) begin
          stage_q <= stage_in;
        end
      end

      assign shift_reg[stage] = stage_q;
    end
  endgenerate

  // ==========================================================
  // Chain output bit
  logic sdo_bit;
  wire shift_out;

  assign shift_out = shift_reg[DWSL_WORD_BITS-1];

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sdo_bit <= DWSL_SDO_INIT;
    end else if (shift_en) begin
      sdo_bit <= shift_out;
    end
  end

  // ==========================================================
  // Address and setting fields
  wire [1:0] word_addr;
  wire dwsl_code_t word_data;
  wire load_en;

  assign word_addr = {shift_reg[DWSL_ADDR_HI_POS], shift_reg[DWSL_ADDR_LO_POS]};
  assign word_data = shift_reg[DWSL_DATA_BITS-1:0];
  assign load_en = cs_rise & pdn_s;

  // ==========================================================
  // Latch select
  wire [DWSL_CHANNELS-1:0] latch_sel;

  assign latch_sel[0] = (word_addr == DWSL_ADDR_CH0);
  assign latch_sel[1] = (word_addr == DWSL_ADDR_CH1);

  // ==========================================================
  // Wiper latches and effective codes
  wire [DWSL_CHANNELS*DWSL_DATA_BITS-1:0] code_eff;

  genvar ch;

  generate
    for (ch = 0; ch < DWSL_CHANNELS; ch++) begin : g_ch
      dwsl_code_t latch_q;
      wire latch_load;
      wire dwsl_code_t code_sel;

      assign latch_load = load_en & latch_sel[ch];

      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          latch_q <= DWSL_MIDSCALE;
        end else if (latch_load) begin
          latch_q <= word_data;
        end
      end

      // Tap zero is the low end while powered down
      assign code_sel = pdn_s ? latch_q : DWSL_CODE_LOW;
      assign code_eff[ch*DWSL_DATA_BITS +: DWSL_DATA_BITS] = code_sel;
    end
  endgenerate

  // ==========================================================
  // Wiper codes
  assign wiper_code_o = code_eff;
  assign wiper_tap0_o = code_eff[7:0];
  assign wiper_tap1_o = code_eff[15:8];

  // ==========================================================
  // High-end switch
  assign high_end_open_o = ~pdn_s;

  // ==========================================================
  // Open-drain serial output
  wire chain_active;
  wire sdo_pull_low;

  assign chain_active = pdn_s & ~cs_n_s;
  assign sdo_pull_low = chain_active & ~sdo_bit;
  assign link.serial_out_chain_o = 1'h0;
  assign link.serial_out_chain_oe = sdo_pull_low;
endmodule

// ==== dwsl_host.sv ====
// Host end: sends one 10-bit word per request
module dwsl_host
  import dwsl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  dwsl_link_if.host link,
  input wire logic req_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] code_i,
  input wire logic power_down_n_i,
  output logic ready_o,
  output logic done_o,
  output logic [9:0] echo_o
);
  // ==========================================================
  // Echo synchroniser
  logic sdo_s1;
  logic sdo_s2;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sdo_s1 <= 1'b1;
      sdo_s2 <= 1'b1;
    end else begin
      sdo_s1 <= link.serial_out_chain;
      sdo_s2 <= sdo_s1;
    end
  end

  // ==========================================================
  // Word sequencer
  dwsl_state_e state;
  dwsl_state_e next_state;
  logic [3:0] half_cnt;
  logic [4:0] bit_cnt;
  logic [9:0] word;
  logic sclk;
  logic cs_n;
  logic pdn;
  wire half_done = (half_cnt == 4'h0);
  wire last_bit = (bit_cnt == 5'(DWSL_WORD_BITS - 1));
  always_comb begin
    next_state = state;
    case (state)
      DWSL_IDLE: if (req_i) next_state = DWSL_LOW;
      DWSL_LOW: if (half_done) next_state = DWSL_HIGH;
      DWSL_HIGH: if (half_done) next_state = last_bit ? DWSL_DONE : DWSL_LOW;
      DWSL_DONE: if (half_done) next_state = DWSL_IDLE;
      default: next_state = DWSL_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= DWSL_IDLE;
      half_cnt <= DWSL_HALF_CNT;
      bit_cnt <= DWSL_BIT_CNT_INIT;
      word <= '0;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      pdn <= 1'b1;
      echo_o <= '0;
    end else begin
      state <= next_state;
      pdn <= power_down_n_i;
      half_cnt <= (state == DWSL_IDLE || half_done) ? DWSL_HALF_CNT : half_cnt - 4'h1;
      case (state)
        DWSL_IDLE: if (req_i) begin
          word <= {addr_i, code_i};
          bit_cnt <= DWSL_BIT_CNT_INIT;
          cs_n <= 1'b0;
        end
        DWSL_LOW: if (half_done) begin
          sclk <= 1'b1;
          echo_o <= {echo_o[8:0], sdo_s2};
        end
        DWSL_HIGH: if (half_done) begin
          sclk <= 1'b0;
          word <= {word[8:0], 1'b0};
          bit_cnt <= bit_cnt + 5'h01;
          if (last_bit) cs_n <= 1'b1;
        end
        DWSL_DONE: ;
        default: ;
      endcase
    end
  end
  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.serial_in = word[9];
  assign link.power_down_n = pdn;
  assign ready_o = (state == DWSL_IDLE);
  assign done_o = (state == DWSL_DONE) & half_done;
endmodule

// ==== dwsl_link_asserts.sv ====
// Checker of the serial link between the host and loader ends
module dwsl_link_asserts (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic power_down_n,
  input wire logic serial_out_chain_o,
  input wire logic serial_out_chain_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] rises;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rises <= 4'h0;
    end else if (cs_n) begin
      rises <= 4'h0;
    end else if ($rose(sclk)) begin
      rises <= rises + 4'h1;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========
  // Assertions
  property p_pd_off; !power_down_n [*3] |-> !serial_out_chain_oe; endproperty
  a_pd_off: assert property (p_pd_off) else $error("driver on in power-down");
  property p_cs_off; cs_n [*4] |-> !serial_out_chain_oe; endproperty
  a_cs_off: assert property (p_cs_off) else $error("driver on while idle");
  property p_drain; serial_out_chain_oe |-> !serial_out_chain_o; endproperty
  a_drain: assert property (p_drain) else $error("output drives high");
  property p_half; $rose(sclk) |=> sclk [*3] ##1 !sclk; endproperty
  a_half: assert property (p_half) else $error("clock high phase wrong");
  property p_idle; cs_n |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("clock moves while idle");
  property p_hold; sclk |-> $stable(serial_in); endproperty
  a_hold: assert property (p_hold) else $error("data moves while clock high");
  property p_lead; $fell(cs_n) |-> !sclk [*3]; endproperty
  a_lead: assert property (p_lead) else $error("clock too soon after select");
  property p_ten; $rose(cs_n) |-> rises == 4'ha; endproperty
  a_ten: assert property (p_ten) else $error("word not ten bits");
  c_word: cover property ($rose(cs_n));
  c_pd: cover property ($fell(power_down_n));
  c_drive: cover property ($rose(serial_out_chain_oe));
endmodule

// ==== dual_wiper_serial_loader_tb.sv ====
// Testbench: host end driving loader end over the link
module dual_wiper_serial_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic req_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] code_i = 8'h00;
  logic power_down_n_i = 1'b1;
  logic ready_o, done_o, high_end_open_o;
  logic [9:0] echo_o;
  logic [7:0] wiper_tap0_o, wiper_tap1_o;
  logic [15:0] wiper_code_o;
  int errors = 0;
  int total_checks = 0;
  logic [26:0] notes [$];
  logic [9:0] prev = 10'h000;
  logic [7:0] lat0 = 8'h80;
  logic [7:0] lat1 = 8'h80;
  always #4 sys_clk_i = ~sys_clk_i;
  dwsl_link_if dwsl_link_if_i ();
  dwsl_host dwsl_host_i (.sys_clk_i, .rstn_i, .link(dwsl_link_if_i), .req_i, .addr_i,
    .code_i, .power_down_n_i, .ready_o, .done_o, .echo_o);
  dwsl_device dwsl_device_i (.sys_clk_i, .rstn_i, .link(dwsl_link_if_i), .wiper_tap0_o,
    .wiper_tap1_o, .high_end_open_o, .wiper_code_o);
  dwsl_link_asserts dwsl_link_asserts_i (.sys_clk_i, .rstn_i, .sclk(dwsl_link_if_i.sclk),
    .cs_n(dwsl_link_if_i.cs_n), .serial_in(dwsl_link_if_i.serial_in),
    .power_down_n(dwsl_link_if_i.power_down_n),
    .serial_out_chain_o(dwsl_link_if_i.serial_out_chain_o),
    .serial_out_chain_oe(dwsl_link_if_i.serial_out_chain_oe));
  task automatic stop_test();
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_echo(input logic [9:0] e, input logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD echo exp %h got %h", e, g);
    end
  endtask
  task automatic chk_tap(input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD tap exp %h got %h", e, g);
    end
  endtask
  task automatic send(input logic [1:0] a, input logic [7:0] d, input logic p);
    do @(posedge sys_clk_i); while (ready_o !== 1'b1);
    addr_i <= a;
    code_i <= d;
    power_down_n_i <= p;
    req_i <= 1'b1;
    @(posedge sys_clk_i);
    req_i <= 1'b0;
    if (p && a == 2'h0) lat0 = d;
    if (p && a == 2'h1) lat1 = d;
    notes.push_back({p ? {1'h1, prev[9:1]} : 10'h3ff, p ? {lat1, lat0} : 16'h0000, !p});
    prev = {a, d};
  endtask
  // ==========
  // Result watcher
  initial begin
    logic [26:0] n;
    forever begin
      @(posedge sys_clk_i);
      if (done_o === 1'b1 && notes.size() > 0) begin
        n = notes.pop_front();
        chk_echo(n[26:17], echo_o);
        repeat (2) @(posedge sys_clk_i);
        chk_tap(n[16:1], wiper_code_o);
        chk_tap(n[16:1], {wiper_tap1_o, wiper_tap0_o});
        chk_tap({15'h0000, n[0]}, {15'h0000, high_end_open_o});
        chk_tap(16'h0001, {15'h0000, ready_o});
      end
    end
  end
  // ==========
  // Stimulus
  initial begin
    void'($urandom(32'h225f));
    repeat (10) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    chk_tap(16'h8080, wiper_code_o);
    send(2'h0, 8'h00, 1'b1);
    send(2'h1, 8'hff, 1'b1);
    send(2'h1, 8'h5a, 1'b0);
    repeat (14) send(2'($urandom_range(3)), 8'($urandom), $urandom_range(3) != 0);
    send(2'h0, 8'h3c, 1'b1);
    wait (notes.size() == 0);
    repeat (8) @(posedge sys_clk_i);
    stop_test();
  end
  initial begin
    #60000;
    errors++;
    stop_test();
  end
endmodule
